// file: include/nstrap_pkg.sv
// Package for the trap entry and address forming unit.
// Assumes a 16-bit word bus and byte addresses of 23 bits.
package nstrap_pkg;

   // Widths of address parts and words
   localparam int ADDR_W = 23;
   localparam int SEG_W  = 7;
   localparam int WORD_W = 16;

   // Flag and control word layout and reset value
   localparam int              FCW_SEG_BIT = 15;
   localparam int              FCW_SYS_BIT = 14;
   localparam logic [15:0]     FCW_RST     = 16'hC000;

   // Segment number position inside a segment word
   localparam int SEGWORD_POS = 8;

   // Status words saved and status area words read, as last step index
   localparam logic [1:0] LAST_STEP = 2'h3;
   // Step of the status area entry that holds the flag and control word
   localparam logic [1:0] PSA_FCW_STEP = 2'h1;
   localparam logic [1:0] PSA_SEG_STEP = 2'h2;

   // Status area entry size as a shift (four words, eight bytes)
   localparam int PSA_ENTRY_SHIFT = 3;
   // Byte distance of one word
   localparam logic [15:0] WORD_BYTES  = 16'h0002;
   localparam logic [22:0] WORD_BYTES_A = 23'h00_0002;

   // Vector bit that must be clear for a legal vectored interrupt
   localparam int VEC_ODD_BIT = 0;

   // Execution cost figures
   localparam logic [1:0] RET_EXTRA_CYC   = 2'h3;
   localparam logic       FULL_EXTRA_WORD = 1'h1;

   // Bus status codes driven with every access
   localparam logic [3:0] ST_CODE_MEM   = 4'h8;
   localparam logic [3:0] ST_CODE_STACK = 4'h9;

   // Operand addressing kinds
   localparam logic [1:0] AK_DIR_FULL  = 2'h0;
   localparam logic [1:0] AK_DIR_SHORT = 2'h1;
   localparam logic [1:0] AK_INDEXED   = 2'h2;
   localparam logic [1:0] AK_REG_IND   = 2'h3;

   // Operand address request
   typedef struct packed {
      logic [1:0]  kind;
      logic        is_ret;
      logic        reg_is_sp;
      logic [6:0]  seg;
      logic [15:0] off;
      logic [6:0]  reg_seg;
      logic [15:0] reg_val;
   } nstrap_areq_s;

   // Trap entry sequencer states, Gray along the path
   typedef enum logic [1:0] {
      TS_IDLE = 2'b00,
      TS_PUSH = 2'b01,
      TS_READ = 2'b11,
      TS_DONE = 2'b10
   } nstrap_state_e;

endpackage

// file: hdl/nstrap_addr.sv
// Operand address former and cost decoder, purely combinational.
// Assumes the caller registers every result.
module nstrap_addr (
   // Mode and program counter segment
   input  wire logic                      seg_mode,
   input  wire logic [6:0]                pc_seg,
   // Request
   input  wire nstrap_pkg::nstrap_areq_s  req,
   // Results
   output logic [22:0]                    addr,
   output logic [3:0]                     status,
   output logic                           extra_word,
   output logic [1:0]                     extra_cyc
);

   // Offset sum wraps inside the segment, as the offset is 16 bits
   function automatic logic [15:0] off_add(input logic [15:0] a,
                                           input logic [15:0] b);
      off_add = a + b;
   endfunction

   wire logic        is_idx  = (req.kind == nstrap_pkg::AK_INDEXED);
   wire logic        is_rind = (req.kind == nstrap_pkg::AK_REG_IND);
   wire logic        is_full = (req.kind == nstrap_pkg::AK_DIR_FULL);
   wire logic [15:0] off_sel = is_idx  ? off_add(req.off, req.reg_val) :
                               is_rind ? req.reg_val : req.off;
   wire logic [6:0]  seg_sel = is_rind ? req.reg_seg : req.seg;

   // Nonsegmented code borrows the segment of the program counter
   assign addr = {(seg_mode ? seg_sel : pc_seg),
                  off_sel};
   // Only the stack pointer as address register gives stack status
   assign status = (is_rind && req.reg_is_sp) ?
                   nstrap_pkg::ST_CODE_STACK :
                   nstrap_pkg::ST_CODE_MEM;
   // Full segmented direct and indexed forms carry a second word
   assign extra_word = (seg_mode && (is_full || is_idx)) ?
                       nstrap_pkg::FULL_EXTRA_WORD : 1'h0;
   // A return pops one more word in segmented mode
   assign extra_cyc = (seg_mode && req.is_ret) ?
                      nstrap_pkg::RET_EXTRA_CYC : 2'h0;

endmodule // nstrap_addr

// file: hdl/nstrap_top.sv
// Mode control, operand address forming and trap entry sequencer.
// Assumes a same-clock word memory that answers with mem_ack.
//
// Notes on behaviour
// - Addresses are 23 bits; segmented mode carries segment and offset.
// - Nonsegmented addresses are 16-bit; segment comes from the counter.
// - Nonsegmented indexed offset is displacement plus register.
// - A return costs three more cycles in segmented mode.
// - Full direct or indexed segmented forms add a word; short form none.
// - Stack status only for stack pointer addressing, never for indexed.
// - Trap entry pushes offset, segment, control word, reason on top.
// - Only even vector bytes are legal vectored interrupts.
// - Each status area entry is read as four words in every mode.
// - Nonsegmented register fourteen is one register in both modes.
// - Trap entry forces segmented system mode; fourteen maps to stack.
// - New control word with segment bit clear returns to nonsegmented.
module nstrap_top (
   // Clock and reset
   input  wire logic                      sys_clk,
   input  wire logic                      rst_b,
   // Control word write from system software
   input  wire logic                      fcw_wr,
   input  wire logic [15:0]               fcw_wdata,
   // Operand address requests
   input  wire logic                      areq_valid,
   input  wire nstrap_pkg::nstrap_areq_s  areq,
   input  wire logic [6:0]                pc_seg,
   input  wire logic [15:0]               pc_off,
   // Trap requests
   input  wire logic                      trap_req,
   input  wire logic [15:0]               trap_reason,
   input  wire logic                      trap_vectored,
   input  wire logic [7:0]                trap_vector,
   input  wire logic [7:0]                trap_entry,
   input  wire logic [6:0]                sp_seg,
   input  wire logic [15:0]               sp_off,
   input  wire logic [22:0]               status_area_pointer,
   // Memory word port
   input  wire logic [15:0]               mem_rdata,
   input  wire logic                      mem_ack,
   output logic                           mem_req_q,
   output logic                           mem_we_q,
   output logic [22:0]                    mem_addr_q,
   output logic [15:0]                    mem_wdata_q,
   output logic [3:0]                     bus_status_outputs_q,
   // Address results
   output logic                           addr_valid_q,
   output logic [22:0]                    addr_q,
   output logic                           extra_word_q,
   output logic [1:0]                     extra_cyc_q,
   // Mode and trap results
   output logic [15:0]                    flag_control_word_q,
   output logic                           r14_stack_seg_q,
   output logic                           trap_busy_q,
   output logic                           trap_reject_q,
   output logic                           trap_done_q,
   output logic [6:0]                     new_pc_seg_q,
   output logic [15:0]                    new_pc_off_q,
   output logic [15:0]                    new_sp_off_q
);

   nstrap_pkg::nstrap_state_e state_q;
   logic [1:0]  step_q;
   logic [15:0] old_fcw_q;
   logic [15:0] reason_q;
   logic [6:0]  sav_pc_seg_q;
   logic [15:0] sav_pc_off_q;
   logic [6:0]  sp_seg_q;
   logic [15:0] sp_ptr_q;
   logic [15:0] fcw_d;

   // Address former results
   logic [22:0] af_addr;
   logic [3:0]  af_status;
   logic        af_word;
   logic [1:0]  af_cyc;

   // Status word for a push step: offset first so reason ends on top
   function automatic logic [15:0] push_word(input logic [1:0] k,
      input logic [15:0] off, input logic [6:0] seg,
      input logic [15:0] flag_control_word, input logic [15:0] rsn);
      case (k)
         2'h0:    push_word = off;
         2'h1:    push_word = {1'b0, seg, 8'h00};
         2'h2:    push_word = flag_control_word;
         default: push_word = rsn;
      endcase
   endfunction

   wire logic seg_mode = flag_control_word_q[nstrap_pkg::FCW_SEG_BIT];
   wire logic sys_mode = flag_control_word_q[nstrap_pkg::FCW_SYS_BIT];
   wire logic idle     = (state_q == nstrap_pkg::TS_IDLE);

   // Trap admission: odd vectors are refused, busy time ignores requests
   wire logic vec_odd   = trap_vectored && trap_vector[nstrap_pkg::VEC_ODD_BIT];
   wire logic accept    = idle && trap_req && !vec_odd;
   wire logic refuse    = idle && trap_req && vec_odd;
   wire logic push_ack  = (state_q == nstrap_pkg::TS_PUSH) && mem_ack;
   wire logic read_ack  = (state_q == nstrap_pkg::TS_READ) && mem_ack;
   wire logic last_step = (step_q == nstrap_pkg::LAST_STEP);
   wire logic fcw_load  = read_ack && (step_q == nstrap_pkg::PSA_FCW_STEP);
   // Software change is honoured only in system mode and outside entry
   wire logic sw_write  = fcw_wr && sys_mode && idle && !trap_req;

   // Entry base: eight bytes per entry whatever the mode
   wire logic [22:0] psa_base = status_area_pointer +
      {12'h000, trap_entry, 3'b000};
   wire logic [15:0] sp_next  = sp_ptr_q - nstrap_pkg::WORD_BYTES;
   wire logic [15:0] sp_first = sp_off - nstrap_pkg::WORD_BYTES;
   wire logic [1:0]  step_inc = step_q + 2'h1;

   // Control word next value; trap entry wins over a software write
   always_comb begin
      fcw_d = flag_control_word_q;
      if (accept) begin
         fcw_d[nstrap_pkg::FCW_SEG_BIT] = 1'b1;
         fcw_d[nstrap_pkg::FCW_SYS_BIT] = 1'b1;
      end else if (fcw_load) begin
         fcw_d = mem_rdata;
      end else if (sw_write) begin
         fcw_d = fcw_wdata;
      end
   end

   // Control word and register fourteen mapping
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         flag_control_word_q <= nstrap_pkg::FCW_RST;
         r14_stack_seg_q     <= 1'b1;
      end else begin
         flag_control_word_q <= fcw_d;
         // Nonsegmented: one physical register whatever the system bit
         r14_stack_seg_q <= fcw_d[nstrap_pkg::FCW_SEG_BIT] &&
            fcw_d[nstrap_pkg::FCW_SYS_BIT];
      end
   end

   nstrap_addr u_addr (
      .seg_mode   (seg_mode),
      .pc_seg     (pc_seg),
      .req        (areq),
      .addr       (af_addr),
      .status     (af_status),
      .extra_word (af_word),
      .extra_cyc  (af_cyc)
   );

   // Operand address results, one cycle after the request
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         addr_valid_q <= 1'b0;
         addr_q       <= 23'h00_0000;
         extra_word_q <= 1'b0;
         extra_cyc_q  <= 2'h0;
      end else begin
         addr_valid_q <= areq_valid;
         if (areq_valid) begin
            addr_q       <= af_addr;
            extra_word_q <= af_word;
            extra_cyc_q  <= af_cyc;
         end
      end
   end

   // Bus status: stack pushes carry the stack code, idle follows operands
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         bus_status_outputs_q <= nstrap_pkg::ST_CODE_MEM;
      end else if (accept || (push_ack && !last_step)) begin
         bus_status_outputs_q <= nstrap_pkg::ST_CODE_STACK;
      end else if (push_ack) begin
         bus_status_outputs_q <= nstrap_pkg::ST_CODE_MEM;
      end else if (idle && areq_valid) begin
         bus_status_outputs_q <= af_status;
      end
   end

   // Trap entry sequencer: four pushes, then four status area reads
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_q      <= nstrap_pkg::TS_IDLE;
         step_q       <= 2'h0;
         old_fcw_q    <= 16'h0000;
         reason_q     <= 16'h0000;
         sav_pc_seg_q <= 7'h00;
         sav_pc_off_q <= 16'h0000;
         sp_seg_q     <= 7'h00;
         sp_ptr_q     <= 16'h0000;
         mem_req_q    <= 1'b0;
         mem_we_q     <= 1'b0;
         mem_addr_q   <= 23'h00_0000;
         mem_wdata_q  <= 16'h0000;
         trap_busy_q  <= 1'b0;
         trap_done_q  <= 1'b0;
         new_pc_seg_q <= 7'h00;
         new_pc_off_q <= 16'h0000;
         new_sp_off_q <= 16'h0000;
      end else begin
         trap_done_q <= 1'b0;
         case (state_q)
            nstrap_pkg::TS_IDLE: begin
               if (accept) begin
                  state_q      <= nstrap_pkg::TS_PUSH;
                  step_q       <= 2'h0;
                  old_fcw_q    <= flag_control_word_q;
                  reason_q     <= trap_reason;
                  sav_pc_seg_q <= pc_seg;
                  sav_pc_off_q <= pc_off;
                  sp_seg_q     <= sp_seg;
                  sp_ptr_q     <= sp_first;
                  mem_req_q    <= 1'b1;
                  mem_we_q     <= 1'b1;
                  mem_addr_q   <= {sp_seg, sp_first};
                  mem_wdata_q  <= pc_off;
                  trap_busy_q  <= 1'b1;
               end
            end
            nstrap_pkg::TS_PUSH: begin
               if (mem_ack && last_step) begin
                  state_q      <= nstrap_pkg::TS_READ;
                  step_q       <= 2'h0;
                  mem_we_q     <= 1'b0;
                  mem_addr_q   <= psa_base;
                  new_sp_off_q <= sp_ptr_q;
               end else if (mem_ack) begin
                  step_q      <= step_inc;
                  sp_ptr_q    <= sp_next;
                  mem_addr_q  <= {sp_seg_q, sp_next};
                  mem_wdata_q <= push_word(step_inc, sav_pc_off_q,
                     sav_pc_seg_q, old_fcw_q, reason_q);
               end
            end
            nstrap_pkg::TS_READ: begin
               if (mem_ack) begin
                  step_q     <= step_inc;
                  mem_addr_q <= mem_addr_q + nstrap_pkg::WORD_BYTES_A;
                  if (step_q == nstrap_pkg::PSA_SEG_STEP) begin
                     new_pc_seg_q <= mem_rdata[nstrap_pkg::SEGWORD_POS +: 7];
                  end
                  if (last_step) begin
                     new_pc_off_q <= mem_rdata;
                     mem_req_q    <= 1'b0;
                     trap_done_q  <= 1'b1;
                     state_q      <= nstrap_pkg::TS_DONE;
                  end
               end
            end
            nstrap_pkg::TS_DONE: begin
               trap_busy_q <= 1'b0;
               state_q     <= nstrap_pkg::TS_IDLE;
            end
            default: begin
               state_q <= nstrap_pkg::TS_IDLE;
            end
         endcase
      end
   end

   // Refusal of an odd vector is a one-cycle pulse
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         trap_reject_q <= 1'b0;
      end else begin
         trap_reject_q <= refuse;
      end
   end

   // Helper counters of words moved during one entry
   logic [2:0] n_wr_q;
   logic [2:0] n_rd_q;
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         n_wr_q <= 3'h0;
         n_rd_q <= 3'h0;
      end else if (accept) begin
         n_wr_q <= 3'h0;
         n_rd_q <= 3'h0;
      end else begin
         n_wr_q <= n_wr_q + {2'h0, push_ack};
         n_rd_q <= n_rd_q + {2'h0, read_ack};
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);

   a_push_count: assert property (trap_done_q |-> n_wr_q == 3'h4)
      else $error("entry did not push four words");
   a_reason_top: assert property (push_ack && last_step |->
      mem_wdata_q == reason_q && mem_addr_q[15:0] == sp_ptr_q)
      else $error("top pushed word is not the reason");
   a_psa_reads: assert property (trap_done_q |-> n_rd_q == 3'h4)
      else $error("status area entry not read as four words");
   a_odd_refused: assert property (refuse |=>
      trap_reject_q && !trap_busy_q)
      else $error("odd vector was not refused");
   a_entry_segsys: assert property (accept |=>
      seg_mode && sys_mode && r14_stack_seg_q)
      else $error("entry did not force segmented system mode");
   a_mode_follows: assert property (fcw_load |=>
      seg_mode == $past(mem_rdata[15]))
      else $error("mode does not follow loaded control word");
   a_sw_gate: assert property (fcw_wr && !sys_mode && !accept
      && !fcw_load |=> $stable(flag_control_word_q))
      else $error("normal mode changed the control word");
   a_r14_shared: assert property (!seg_mode |-> !r14_stack_seg_q)
      else $error("register fourteen split in nonsegmented mode");
   a_nonseg_seg: assert property (areq_valid && !seg_mode
      && !accept && !fcw_load && !sw_write
      |=> addr_q[22:16] == $past(pc_seg))
      else $error("nonsegmented address segment not from counter");
   a_idx_sum: assert property (areq_valid &&
      areq.kind == nstrap_pkg::AK_INDEXED |=>
      addr_q[15:0] == $past(areq.off) + $past(areq.reg_val))
      else $error("indexed offset is not displacement plus register");
   a_idx_nostack: assert property (idle && areq_valid && !accept &&
      areq.kind == nstrap_pkg::AK_INDEXED |=>
      bus_status_outputs_q == nstrap_pkg::ST_CODE_MEM)
      else $error("indexed access gave stack status");
   a_ret_cost: assert property (areq_valid && areq.is_ret |=>
      extra_cyc_q == ($past(seg_mode) ? 2'h3 : 2'h0))
      else $error("return cost wrong for mode");
   a_short_word: assert property (areq_valid &&
      areq.kind == nstrap_pkg::AK_DIR_SHORT |=> extra_word_q == 1'b0)
      else $error("short form reported an extra word");

   c_refused: cover property (refuse);
   c_entry_done: cover property (accept ##[8:40] trap_done_q);
   c_back_nonseg: cover property (fcw_load && !mem_rdata[15]);

endmodule // nstrap_top

// file: testbench/nstrap_mem.sv
// Word memory on the far side of the trap unit, behavioural.
// Assumes the unit holds each request until it samples mem_ack.
module nstrap_mem (
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst_b,
   // Word port from the unit
   input  wire logic        mem_req_q,
   input  wire logic        mem_we_q,
   input  wire logic [22:0] mem_addr_q,
   input  wire logic [15:0] mem_wdata_q,
   // Idle cycles before each answer
   input  wire logic [1:0]  lat,
   // Answer
   output logic             mem_ack,
   output logic [15:0]      mem_rdata
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [15:0] mem [0:255];
   logic [22:0] alog [$];
   logic [15:0] dlog [$];
   logic [1:0]  wait_q;

   // One ack per access after lat idle cycles; every access is logged.
   // Read data flips outside ack so a stale word never passes for valid.
   always @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         mem_ack <= 1'b0;
         wait_q <= 2'h0;
         mem_rdata <= 16'h0000;
      end else begin
         mem_ack <= 1'b0;
         mem_rdata <= ~mem_rdata;
         if (mem_req_q && !mem_ack) begin
            if (wait_q == lat) begin
               mem_ack <= 1'b1;
               wait_q <= 2'h0;
               alog.push_back(mem_addr_q);
               dlog.push_back(mem_we_q ? mem_wdata_q : mem[mem_addr_q[8:1]]);
               if (mem_we_q) mem[mem_addr_q[8:1]] <= mem_wdata_q;
               else mem_rdata <= mem[mem_addr_q[8:1]];
            end else begin
               wait_q <= wait_q + 2'h1;
            end
         end
      end
   end
endmodule // nstrap_mem

// file: testbench/tb_top.sv
// Self-checking bench for the trap entry and address forming unit.
// Assumes a single 100 MHz clock; the memory model answers all accesses.
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;

   logic sys_clk, rst_b, fcw_wr, areq_valid, trap_req, trap_vectored;
   logic [15:0] fcw_wdata, pc_off, trap_reason, sp_off, mem_rdata;
   logic [6:0]  pc_seg, sp_seg, new_pc_seg_q;
   logic [7:0]  trap_vector, trap_entry;
   logic [22:0] status_area_pointer, mem_addr_q, addr_q;
   logic        mem_ack, mem_req_q, mem_we_q, addr_valid_q, extra_word_q;
   logic [15:0] mem_wdata_q, flag_control_word_q, new_pc_off_q, new_sp_off_q;
   logic [3:0]  bus_status_outputs_q;
   logic [1:0]  extra_cyc_q, lat;
   logic        r14_stack_seg_q, trap_busy_q, trap_reject_q, trap_done_q;
   nstrap_pkg::nstrap_areq_s areq;
   int          mismatches, checks, cyc;

   nstrap_top i_nstrap_top (.sys_clk, .rst_b, .fcw_wr, .fcw_wdata,
      .areq_valid, .areq, .pc_seg, .pc_off, .trap_req, .trap_reason,
      .trap_vectored, .trap_vector, .trap_entry, .sp_seg, .sp_off,
      .status_area_pointer, .mem_rdata, .mem_ack, .mem_req_q, .mem_we_q,
      .mem_addr_q, .mem_wdata_q, .bus_status_outputs_q, .addr_valid_q,
      .addr_q, .extra_word_q, .extra_cyc_q, .flag_control_word_q,
      .r14_stack_seg_q, .trap_busy_q, .trap_reject_q, .trap_done_q,
      .new_pc_seg_q, .new_pc_off_q, .new_sp_off_q);

   nstrap_mem i_nstrap_mem (.sys_clk, .rst_b, .mem_req_q, .mem_we_q,
      .mem_addr_q, .mem_wdata_q, .lat, .mem_ack, .mem_rdata);

   // Free-running clock, 10 ns period
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   // Hang guard; the tests need well under a thousand cycles
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 3000) begin
         mismatches++;
         summarize();
      end
   end

   // Inputs always change 1 ns after the rising edge
   task automatic tick();
      @(posedge sys_clk);
      #1;
   endtask

   task automatic chk(input logic [22:0] got, input logic [22:0] exp);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic summarize();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   // Software control word write, one cycle
   task automatic fcw_write(input logic [15:0] v);
      fcw_wr = 1'b1;
      fcw_wdata = v;
      tick();
      fcw_wr = 1'b0;
      tick();
   endtask

   // One address request; results are judged the cycle after it is taken
   task automatic addr_case(input logic [1:0] k, input logic ret, sp,
      input logic [15:0] off, rv, input logic [22:0] ea,
      input logic xw, input logic [1:0] xc, input logic [3:0] st);
      areq = {k, ret, sp, 7'h12, off, 7'h12, rv};
      areq_valid = 1'b1;
      tick();
      areq_valid = 1'b0;
      chk(addr_valid_q, 1'b1);
      chk(addr_q, ea);
      chk(extra_word_q, xw);
      chk(extra_cyc_q, xc);
      chk(bus_status_outputs_q, st);
      tick();
   endtask

   task automatic load_entry(input int b, input logic [15:0] f, s, o);
      i_nstrap_mem.mem[b+1] = f;
      i_nstrap_mem.mem[b+2] = s;
      i_nstrap_mem.mem[b+3] = o;
      i_nstrap_mem.alog.delete();
      i_nstrap_mem.dlog.delete();
   endtask

   task automatic trap_start(input logic v, input logic [7:0] vec, e);
      trap_req = 1'b1;
      trap_vectored = v;
      trap_vector = vec;
      trap_entry = e;
      tick();
      trap_req = 1'b0;
   endtask

   // Bounded wait for completion, then a check that eight accesses were logged
   task automatic trap_finish();
      int n;
      n = 0;
      while (trap_done_q !== 1'b1 && n < 200) begin
         tick();
         n++;
      end
      chk(trap_done_q, 1'b1);
      chk(23'(i_nstrap_mem.alog.size()), 23'h00_0008);
   endtask

   task automatic t_reset();
      chk(flag_control_word_q, 16'hC000);
      chk(r14_stack_seg_q, 1'b1);
      chk(bus_status_outputs_q, 4'h8);
      $display("test reset done");
   endtask

   task automatic t_seg_addr();
      addr_case(2'h0, 1, 0, 16'h3456, 16'h0000, 23'h12_3456,
         1, 2'h3, 4'h8);
      addr_case(2'h1, 0, 0, 16'h3456, 16'h0000, 23'h12_3456,
         0, 2'h0, 4'h8);
      addr_case(2'h2, 0, 1, 16'h0004, 16'h1000, 23'h12_1004,
         1, 2'h0, 4'h8);
      addr_case(2'h3, 0, 1, 16'h0000, 16'h0200, 23'h12_0200,
         0, 2'h0, 4'h9);
      $display("test segmented addressing done");
   endtask

   task automatic t_nonseg_addr();
      fcw_write(16'h4000);
      chk(flag_control_word_q, 16'h4000);
      chk(r14_stack_seg_q, 1'b0);
      addr_case(2'h0, 1, 0, 16'h3456, 16'h0000, 23'h33_3456,
         0, 2'h0, 4'h8);
      addr_case(2'h2, 0, 1, 16'hFFF0, 16'h0020, 23'h33_0010,
         0, 2'h0, 4'h8);
      addr_case(2'h3, 0, 1, 16'h0000, 16'h0200, 23'h33_0200,
         0, 2'h0, 4'h9);
      $display("test nonsegmented addressing done");
   endtask

   // Slow memory, entry 2 whose control word leaves segmentation off
   task automatic t_trap_slow();
      logic [15:0] pd [4];
      pd = '{16'h0ABC, 16'h3300, 16'h4000, 16'h5A5A};
      load_entry(8'h28, 16'h4000, 16'h0500, 16'h1234);
      lat = 2'h2;
      trap_start(1'b0, 8'h00, 8'h02);
      chk(trap_busy_q, 1'b1);
      chk(bus_status_outputs_q, 4'h9);
      chk(flag_control_word_q[15:14], 2'h3);
      chk(r14_stack_seg_q, 1'b1);
      trap_finish();
      for (int i = 0; i < 4; i++) begin
         chk(i_nstrap_mem.alog[i], 23'h01_00FE - 23'(2 * i));
         chk(i_nstrap_mem.dlog[i], pd[i]);
         chk(i_nstrap_mem.alog[i+4], 23'h00_0050 + 23'(2 * i));
      end
      chk(new_pc_seg_q, 7'h05);
      chk(new_pc_off_q, 16'h1234);
      chk(new_sp_off_q, 16'h00F8);
      chk(flag_control_word_q, 16'h4000);
      chk(r14_stack_seg_q, 1'b0);
      repeat (2) tick();
      // Handler goes back to segmented system mode before its return
      fcw_write(16'hC000);
      chk(flag_control_word_q, 16'hC000);
      $display("test slow trap done");
   endtask

   task automatic t_odd_vector();
      trap_start(1'b1, 8'h11, 8'h02);
      chk(trap_reject_q, 1'b1);
      chk(trap_busy_q, 1'b0);
      chk(mem_req_q, 1'b0);
      tick();
      $display("test odd vector done");
   endtask

   // Normal mode cannot write the control word; an even vector still traps
   task automatic t_refuse_even();
      fcw_write(16'h8000);
      chk(flag_control_word_q, 16'h8000);
      fcw_write(16'hC000);
      chk(flag_control_word_q, 16'h8000);
      load_entry(8'h2C, 16'hC000, 16'h0200, 16'hABCD);
      lat = 2'h0;
      trap_start(1'b1, 8'h10, 8'h03);
      chk(trap_busy_q, 1'b1);
      trap_finish();
      chk(i_nstrap_mem.dlog[2], 16'h8000);
      chk(i_nstrap_mem.alog[5], 23'h00_005A);
      chk(new_pc_off_q, 16'hABCD);
      chk(flag_control_word_q, 16'hC000);
      chk(r14_stack_seg_q, 1'b1);
      repeat (2) tick();
      $display("test refused write and even vector done");
   endtask

   // Main sequence
   initial begin
      {rst_b, fcw_wr, areq_valid, trap_req, trap_vectored} = 5'h00;
      {fcw_wdata, trap_reason, sp_off} = {16'h0000, 16'h5A5A, 16'h0100};
      {pc_seg, pc_off, sp_seg} = {7'h33, 16'h0ABC, 7'h01};
      {trap_vector, trap_entry, lat} = {8'h00, 8'h00, 2'h0};
      status_area_pointer = 23'h00_0040;
      areq = '0;
      repeat (5) @(posedge sys_clk);
      #1;
      rst_b = 1'b1;
      t_reset();
      t_seg_addr();
      t_nonseg_addr();
      t_trap_slow();
      t_odd_vector();
      t_refuse_even();
      summarize();
   end
endmodule // tb_top
